// ### rtl/bst_cfg.svh
`ifndef BST_CFG_SVH
`define BST_CFG_SVH

// instruction register
`define BST_IR_W          4
`define BST_IR_IDCODE     4'h1
`define BST_IR_BYPASS     4'hf
`define BST_IR_CAPTURE    4'h1

// data register
`define BST_DR_W          32

// pin vector positions after the synchroniser
`define BST_PIN_CLK       0
`define BST_PIN_TMS       1
`define BST_PIN_TDI       2
`define BST_PIN_TRST      3
`define BST_PIN_SCAN_SHIFT_ENABLE    4
`define BST_PIN_SCANSEL   5
`define BST_PIN_DIOEN     6
`define BST_PIN_N         7

`endif

// ### rtl/bst_pkg.sv
package bst_pkg;

    typedef enum logic [15:0] {
        TAP_RESET     = 16'h0001,
        TAP_IDLE      = 16'h0002,
        TAP_SEL_DR    = 16'h0004,
        TAP_CAP_DR    = 16'h0008,
        TAP_SHIFT_DR  = 16'h0010,
        TAP_EXIT1_DR  = 16'h0020,
        TAP_PAUSE_DR  = 16'h0040,
        TAP_EXIT2_DR  = 16'h0080,
        TAP_UPD_DR    = 16'h0100,
        TAP_SEL_IR    = 16'h0200,
        TAP_CAP_IR    = 16'h0400,
        TAP_SHIFT_IR  = 16'h0800,
        TAP_EXIT1_IR  = 16'h1000,
        TAP_PAUSE_IR  = 16'h2000,
        TAP_EXIT2_IR  = 16'h4000,
        TAP_UPD_IR    = 16'h8000
    } bst_tap_state_t;

    // synchronised pin levels and test clock edges
    typedef struct packed {
        logic clkRise;
        logic clkFall;
        logic tms;
        logic tdi;
        logic trstN;
        logic scan_shift_enable;
        logic scanSel;
        logic dioEn;
    } bst_pins_t;

endpackage

// ### rtl/bst_sync.sv
`timescale 1ns/1ps
`include "bst_cfg.svh"

module bst_sync #(
    parameter int W = 7
) (
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] pinAsync,
    output logic      [W-1:0] pinLevel,
    output logic      [W-1:0] pinPrev
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } bst_sync_st_t;

    bst_sync_st_t st_q;
    bst_sync_st_t st_d;

    // s1 feeds only s2; s3 is a delayed copy for edge finding
    always_comb begin
        st_d    = st_q;
        st_d.s1 = pinAsync;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pinLevel = st_q.s2;
    assign pinPrev  = st_q.s3;

endmodule // bst_sync

// ### rtl/bst_tap.sv
// Notes on behaviour
// - mode select sampled at test clock rise steps the standard TAP states.
// - data in captured at test clock rise; controller sets it up earlier.
// - data out shifts out and changes only at test clock fall.
// - scan shift enable low means normal operation; system keeps it low.
// - scan clock select low keeps functional clocks; system keeps it low.
// - test port reset low resets the TAP controller; held low if unused.
// - test reset rising puts the port in device identification mode.
// - io enable low and test reset low put digital pins high impedance.
`timescale 1ns/1ps
`include "bst_cfg.svh"

module bst_tap #(
    parameter logic [`BST_DR_W-1:0] ID_CODE = 32'h0000_0001 // arbitrary
) (
    input  wire logic                   clk_sys,
    input  wire logic                   arst_n,
    input  wire logic                   testClock,
    input  wire logic                   testModeSelect,
    input  wire logic                   testDataIn,
    input  wire logic                   testPortResetN,
    input  wire logic                   scanShiftEnable,
    input  wire logic                   scanClockSelect,
    input  wire logic                   digitalIoEnable,
    output logic                        testDataOut,
    output logic                        testDataOutOen,
    output logic                        digitalIoHiZ,
    output logic                        deviceIdMode,
    output logic                        funcOperate,
    output logic                        funcClocks,
    output bst_pkg::bst_tap_state_t     tapState
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [`BST_PIN_N-1:0] pinLevel;
    logic [`BST_PIN_N-1:0] pinPrev;
    bst_pkg::bst_pins_t    pins;

    bst_sync #(
        .W (`BST_PIN_N)
    ) u_sync (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .pinAsync ({digitalIoEnable, scanClockSelect, scanShiftEnable,
                    testPortResetN, testDataIn, testModeSelect, testClock}),
        .pinLevel (pinLevel),
        .pinPrev  (pinPrev)
    );

    always_comb begin
        pins.clkRise = pinLevel[`BST_PIN_CLK] & ~pinPrev[`BST_PIN_CLK];
        pins.clkFall = ~pinLevel[`BST_PIN_CLK] & pinPrev[`BST_PIN_CLK];
        pins.tms     = pinLevel[`BST_PIN_TMS];
        pins.tdi     = pinLevel[`BST_PIN_TDI];
        pins.trstN   = pinLevel[`BST_PIN_TRST];
        pins.scan_shift_enable  = pinLevel[`BST_PIN_SCAN_SHIFT_ENABLE];
        pins.scanSel = pinLevel[`BST_PIN_SCANSEL];
        pins.dioEn   = pinLevel[`BST_PIN_DIOEN];
    end

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        bst_pkg::bst_tap_state_t tap;
        logic [`BST_IR_W-1:0]    ir;
        logic [`BST_IR_W-1:0]    irSh;
        logic [`BST_DR_W-1:0]    drSh;
        logic                    tdo;
        logic                    tdoOen;
        logic                    hiz;
        logic                    idMode;
        logic                    operate;
        logic                    clocks;
    } bst_tap_st_t;

    bst_tap_st_t st_q;
    bst_tap_st_t st_d;
    logic        inShift;

    assign inShift = (st_q.tap == bst_pkg::TAP_SHIFT_DR) ||
                     (st_q.tap == bst_pkg::TAP_SHIFT_IR);

    always_comb begin
        st_d = st_q;
        // pins of the system side, sampled every cycle
        st_d.operate = ~pins.scan_shift_enable;
        st_d.clocks  = ~pins.scanSel;
        st_d.hiz     = ~pins.dioEn & ~pins.trstN;
        st_d.idMode  = pins.trstN &&
                       (st_q.ir == `BST_IR_IDCODE);
        if (!pins.trstN) begin
            // reset held at sys clock rate; TAP leaves only on a rise
            st_d.tap    = bst_pkg::TAP_RESET;
            st_d.ir     = `BST_IR_IDCODE;
            st_d.tdoOen = 1'b1;
        end else if (pins.clkRise) begin
            case (st_q.tap)
                bst_pkg::TAP_RESET: begin
                    st_d.tap = pins.tms ? bst_pkg::TAP_RESET
                                        : bst_pkg::TAP_IDLE;
                    st_d.ir  = `BST_IR_IDCODE;
                end
                bst_pkg::TAP_IDLE:
                    st_d.tap = pins.tms ? bst_pkg::TAP_SEL_DR
                                        : bst_pkg::TAP_IDLE;
                bst_pkg::TAP_SEL_DR:
                    st_d.tap = pins.tms ? bst_pkg::TAP_SEL_IR
                                        : bst_pkg::TAP_CAP_DR;
                bst_pkg::TAP_CAP_DR: begin
                    st_d.drSh = (st_q.ir == `BST_IR_IDCODE) ? ID_CODE : '0;
                    st_d.tap  = pins.tms ? bst_pkg::TAP_EXIT1_DR
                                         : bst_pkg::TAP_SHIFT_DR;
                end
                bst_pkg::TAP_SHIFT_DR: begin
                    // anything but the id code acts as a one bit bypass
                    if (st_q.ir == `BST_IR_IDCODE) begin
                        st_d.drSh = {pins.tdi,
                                     st_q.drSh[`BST_DR_W-1:1]};
                    end else begin
                        st_d.drSh[0] = pins.tdi;
                    end
                    st_d.tap = pins.tms ? bst_pkg::TAP_EXIT1_DR
                                        : bst_pkg::TAP_SHIFT_DR;
                end
                bst_pkg::TAP_EXIT1_DR:
                    st_d.tap = pins.tms ? bst_pkg::TAP_UPD_DR
                                        : bst_pkg::TAP_PAUSE_DR;
                bst_pkg::TAP_PAUSE_DR:
                    st_d.tap = pins.tms ? bst_pkg::TAP_EXIT2_DR
                                        : bst_pkg::TAP_PAUSE_DR;
                bst_pkg::TAP_EXIT2_DR:
                    st_d.tap = pins.tms ? bst_pkg::TAP_UPD_DR
                                        : bst_pkg::TAP_SHIFT_DR;
                bst_pkg::TAP_UPD_DR:
                    st_d.tap = pins.tms ? bst_pkg::TAP_SEL_DR
                                        : bst_pkg::TAP_IDLE;
                bst_pkg::TAP_SEL_IR:
                    st_d.tap = pins.tms ? bst_pkg::TAP_RESET
                                        : bst_pkg::TAP_CAP_IR;
                bst_pkg::TAP_CAP_IR: begin
                    st_d.irSh = `BST_IR_CAPTURE;
                    st_d.tap  = pins.tms ? bst_pkg::TAP_EXIT1_IR
                                         : bst_pkg::TAP_SHIFT_IR;
                end
                bst_pkg::TAP_SHIFT_IR: begin
                    st_d.irSh = {pins.tdi,
                                 st_q.irSh[`BST_IR_W-1:1]};
                    st_d.tap  = pins.tms ? bst_pkg::TAP_EXIT1_IR
                                         : bst_pkg::TAP_SHIFT_IR;
                end
                bst_pkg::TAP_EXIT1_IR:
                    st_d.tap = pins.tms ? bst_pkg::TAP_UPD_IR
                                        : bst_pkg::TAP_PAUSE_IR;
                bst_pkg::TAP_PAUSE_IR:
                    st_d.tap = pins.tms ? bst_pkg::TAP_EXIT2_IR
                                        : bst_pkg::TAP_PAUSE_IR;
                bst_pkg::TAP_EXIT2_IR:
                    st_d.tap = pins.tms ? bst_pkg::TAP_UPD_IR
                                        : bst_pkg::TAP_SHIFT_IR;
                bst_pkg::TAP_UPD_IR: begin
                    st_d.ir  = st_q.irSh;
                    st_d.tap = pins.tms ? bst_pkg::TAP_SEL_DR
                                        : bst_pkg::TAP_IDLE;
                end
                default:
                    st_d.tap = bst_pkg::TAP_RESET;
            endcase
        end else if (pins.clkFall) begin
            // output moves on the fall that follows the capture edge
            st_d.tdo    = (st_q.tap == bst_pkg::TAP_SHIFT_IR)
                          ? st_q.irSh[0] : st_q.drSh[0];
            st_d.tdoOen = ~inShift;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q         <= '0;
            st_q.tap     <= bst_pkg::TAP_RESET;
            st_q.ir      <= `BST_IR_IDCODE;
            st_q.tdoOen  <= 1'b1;
            st_q.operate <= 1'b1;
            st_q.clocks  <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign testDataOut    = st_q.tdo;
    assign testDataOutOen = st_q.tdoOen;
    assign digitalIoHiZ   = st_q.hiz;
    assign deviceIdMode   = st_q.idMode;
    assign funcOperate    = st_q.operate;
    assign funcClocks     = st_q.clocks;
    assign tapState       = st_q.tap;

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_tap_step: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        pins.trstN && pins.clkRise && st_q.tap == bst_pkg::TAP_RESET &&
        !pins.tms |=> tapState == bst_pkg::TAP_IDLE)
        else $error("tap did not step to idle");

    a_tdi_capture: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        pins.trstN && pins.clkRise && st_q.tap == bst_pkg::TAP_SHIFT_IR
        |=> st_q.irSh[`BST_IR_W-1] == $past(pins.tdi))
        else $error("data in not captured at rise");

    a_tdo_fall: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !$stable(testDataOut) |-> $past(pins.clkFall))
        else $error("data out changed off a falling edge");

    a_scan_normal: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !pins.scan_shift_enable |=> funcOperate)
        else $error("normal operation not shown");

    a_scan_clock: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        pins.scanSel |=> !funcClocks)
        else $error("clock select not followed");

    a_trst_reset: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !pins.trstN |=> tapState == bst_pkg::TAP_RESET && testDataOutOen)
        else $error("test reset did not reset tap");

    // the ir is forced to the id code while reset is low
    a_trst_idmode: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(pins.trstN) |=> deviceIdMode)
        else $error("id mode not entered");

    a_io_hiz: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !pins.dioEn && !pins.trstN |=> digitalIoHiZ)
        else $error("digital pins not high impedance");

    a_io_normal: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        pins.dioEn || pins.trstN |=> !digitalIoHiZ)
        else $error("digital pins left high impedance");

    a_tdo_oen: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        pins.clkFall && pins.trstN |=> testDataOutOen == !$past(inShift))
        else $error("data out enable wrong after fall");

endmodule // bst_tap

// ### bench/bst_ctl_model.sv
`timescale 1ns/1ps

module bst_ctl_model (
    input  wire logic clk_sys,
    input  wire logic testDataOut,
    input  wire logic testDataOutOen,
    output logic      testClock,
    output logic      testModeSelect,
    output logic      testDataIn
);
    logic lastSeen;

    // clock stands still between ticks; released lines float to pull-up
    initial begin
        testClock      = 1'b0;
        testModeSelect = 1'b1;
        testDataIn     = 1'b1;
        lastSeen       = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one test clock period: 3 cycles low, 5 cycles high, 320 ns
    task automatic tick(input logic m, input logic d, output logic o,
                        output logic oe);
        @(posedge clk_sys);
        testClock      <= 1'b0;
        testModeSelect <= m;
        testDataIn     <= d;
        repeat (3) @(posedge clk_sys);
        testClock <= 1'b1; // set up three cycles ahead of the rise
        repeat (4) @(posedge clk_sys);
        #1;
        oe = testDataOutOen;
        // undriven line has no pull, so show the inverse of the last bit
        o = oe ? ~lastSeen : testDataOut;
        lastSeen = o;
    endtask

    task automatic releaseLines();
        @(posedge clk_sys);
        testClock      <= 1'b0;
        testModeSelect <= 1'b1;
        testDataIn     <= 1'b1;
    endtask
endmodule // bst_ctl_model

// ### bench/tb.sv
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
    begin \
        totalChecks++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("wrong value %s expected %h seen %h", nm, exp, got); \
        end \
    end

module tb;
    localparam logic [31:0] ID    = 32'h5a3c_96e1; // arbitrary value
    localparam int          LIMIT = 3000;

    logic                    clk_sys, arst_n, testPortResetN;
    logic                    scanShiftEnable, scanClockSelect;
    logic                    digitalIoEnable, testClock, testModeSelect;
    logic                    testDataIn, testDataOut, testDataOutOen;
    logic                    digitalIoHiZ, deviceIdMode, funcOperate;
    logic                    funcClocks;
    bst_pkg::bst_tap_state_t tapState;
    int                      fails, totalChecks, cycles;

    bst_tap #(.ID_CODE(ID)) u_bst_tap (
        .clk_sys(clk_sys), .arst_n(arst_n), .testClock(testClock),
        .testModeSelect(testModeSelect), .testDataIn(testDataIn),
        .testPortResetN(testPortResetN), .scanShiftEnable(scanShiftEnable),
        .scanClockSelect(scanClockSelect),
        .digitalIoEnable(digitalIoEnable), .testDataOut(testDataOut),
        .testDataOutOen(testDataOutOen), .digitalIoHiZ(digitalIoHiZ),
        .deviceIdMode(deviceIdMode), .funcOperate(funcOperate),
        .funcClocks(funcClocks), .tapState(tapState));

    bst_ctl_model u_bst_ctl_model (
        .clk_sys(clk_sys), .testDataOut(testDataOut),
        .testDataOutOen(testDataOutOen), .testClock(testClock),
        .testModeSelect(testModeSelect), .testDataIn(testDataIn));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            giveVerdict();
        end
    end

    task automatic step(input logic m, input bst_pkg::bst_tap_state_t s);
        logic o, oe;
        u_bst_ctl_model.tick(m, 1'b1, o, oe);
        `CHK("tapState", s, tapState)
    endtask

    // shift n bits lsb first, leaving the shift state on the last one
    task automatic shiftBits(input int n, input logic [63:0] din,
                             input logic [63:0] dout);
        logic o, oe;
        for (int i = 0; i < n; i++) begin
            u_bst_ctl_model.tick(i == n - 1, din[i], o, oe);
            `CHK("testDataOut", dout[i], o)
            `CHK("testDataOutOen", 1'b0, oe)
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [63:0] din;
        logic [15:0] seed;
        logic        o, oe;
        seed = 16'h0040;
        fails = 0;
        totalChecks = 0;
        arst_n = 1'b0;
        testPortResetN = 1'b0;
        scanShiftEnable = 1'b0;
        scanClockSelect = 1'b0;
        digitalIoEnable = 1'b1;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK("tapState", bst_pkg::TAP_RESET, tapState)
        `CHK("testDataOutOen", 1'b1, testDataOutOen)
        $display("test reset done");
        // every enable and reset pairing, scan levels at random
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            @(posedge clk_sys);
            testPortResetN  <= i[0];
            digitalIoEnable <= i[1];
            scanShiftEnable <= seed[0];
            scanClockSelect <= seed[1];
            repeat (4) @(posedge clk_sys);
            #1;
            `CHK("digitalIoHiZ", !i[0] && !i[1], digitalIoHiZ)
            `CHK("funcOperate", !scanShiftEnable, funcOperate)
            `CHK("funcClocks", !scanClockSelect, funcClocks)
        end
        // system keeps scan controls low, test port held in reset
        @(posedge clk_sys);
        scanShiftEnable <= 1'b0;
        scanClockSelect <= 1'b0;
        testPortResetN  <= 1'b0;
        digitalIoEnable <= 1'b1;
        repeat (4) @(posedge clk_sys);
        step(1'b0, bst_pkg::TAP_RESET); // edges ignored in reset
        $display("test pin controls done");
        @(posedge clk_sys);
        testPortResetN <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK("deviceIdMode", 1'b1, deviceIdMode)
        step(1'b0, bst_pkg::TAP_IDLE);
        step(1'b1, bst_pkg::TAP_SEL_DR);
        step(1'b0, bst_pkg::TAP_CAP_DR);
        step(1'b0, bst_pkg::TAP_SHIFT_DR);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            din[k*16 +: 16] = seed;
        end
        // identity first, then the bits fed in come back out
        shiftBits(64, din, {din[31:0], ID});
        `CHK("tapState", bst_pkg::TAP_EXIT1_DR, tapState)
        u_bst_ctl_model.tick(1'b1, 1'b1, o, oe);
        `CHK("testDataOutOen", 1'b1, oe)
        `CHK("tapState", bst_pkg::TAP_UPD_DR, tapState)
        step(1'b0, bst_pkg::TAP_IDLE);
        $display("test identity read done");
        step(1'b1, bst_pkg::TAP_SEL_DR);
        step(1'b1, bst_pkg::TAP_SEL_IR);
        step(1'b0, bst_pkg::TAP_CAP_IR);
        step(1'b0, bst_pkg::TAP_SHIFT_IR);
        shiftBits(4, 64'hf, 64'h1);
        step(1'b1, bst_pkg::TAP_UPD_IR);
        step(1'b0, bst_pkg::TAP_IDLE);
        `CHK("deviceIdMode", 1'b0, deviceIdMode)
        step(1'b1, bst_pkg::TAP_SEL_DR);
        step(1'b0, bst_pkg::TAP_CAP_DR);
        step(1'b0, bst_pkg::TAP_SHIFT_DR);
        seed = lfsr(seed);
        // one-bit bypass path: a captured zero, then a one-bit delay
        shiftBits(8, {48'h0, seed}, {55'h0, seed[6:0], 1'b0});
        step(1'b1, bst_pkg::TAP_UPD_DR);
        $display("test bypass done");
        @(posedge clk_sys);
        testPortResetN <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK("tapState", bst_pkg::TAP_RESET, tapState)
        `CHK("deviceIdMode", 1'b0, deviceIdMode)
        u_bst_ctl_model.releaseLines();
        $display("test port release done");
        giveVerdict();
    end
endmodule // tb
